// [design/cat_consts.svh]
// register offsets, field positions, reset values and timing counts of the counter array timebase
`ifndef CAT_CONSTS_SVH
`define CAT_CONSTS_SVH
// register offsets (8-bit address space)
`define CAT_ADDR_COUNT_LOW   8'h00
`define CAT_ADDR_COUNT_HIGH  8'h01
`define CAT_ADDR_MODE        8'h02
`define CAT_ADDR_MODULE_EN   8'h03
// counter_mode_reg fields
`define CAT_MODE_IDLE_BIT    7
`define CAT_MODE_WDOG_BIT    6
`define CAT_MODE_TBS_HI      3
`define CAT_MODE_TBS_LO      1
`define CAT_MODE_OVIE_BIT    0
`define CAT_MODE_FLAG_BIT    5
// reset values: watchdog on, all else cleared
`define CAT_MODE_RESET       8'h40
`define CAT_MODULE_EN_RESET  6'h00
// timing counts: divider terminal counts in system clocks, oscillator divide in oscillator rising edges
`define CAT_DIV12_COUNT      4'hb
`define CAT_DIV4_COUNT       4'h3
`define CAT_EXT_OSC_DIV      3'h7
`endif

// [design/cat_pkg.sv]
// types of the counter array timebase
package cat_pkg;
  typedef enum logic [2:0] {
    CAT_TB_DIV12   = 3'h0,
    CAT_TB_DIV4    = 3'h1,
    CAT_TB_TMR0    = 3'h2,
    CAT_TB_EXT_PIN = 3'h3,
    CAT_TB_SYSCLK  = 3'h4,
    CAT_TB_EXT_OSC = 3'h5,
    CAT_TB_RSVD6   = 3'h6,
    CAT_TB_RSVD7   = 3'h7
  } cat_timebase_e;
endpackage

// [design/cat_timebase.sv]
// shared 16-bit free-running counter of the programmable counter array
//
// Contract
// - count is one 16-bit counter read as high and low byte registers
// - reading low byte latches high byte; next high read returns that snapshot
// - reads never disturb counting
// - rollover from all-ones to zero sets the overflow flag
// - interrupt request while overflow flag and its enable are both set
// - flag stays set until software writes it to zero
// - idle control clear: counter keeps running in idle mode
// - select codes: div12, div4, timer0 overflow, sysclk; 110/111 reserved
// - code 011 counts falling edges on the external count pin
// - code 101 counts external oscillator divided by 8, synchronized
// - count shared with six capture/compare modules, each with an io line
// - module 5 starts as watchdog after every reset
// - watchdog active restricts access to some registers
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "cat_consts.svh"

module cat_timebase (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        cpu_idle,
  input  wire logic        tmr0_overflow,
  input  wire logic        ext_count_input,
  input  wire logic        ext_osc_clk,
  output logic      [15:0] prog_counter_array,
  output logic      [5:0]  module_enable,
  output logic             watchdog_mode,
  output logic             counter_irq
);

  // =====================================================================
  // registers
  logic [15:0] count_q;
  logic [7:0]  snap_high_q;
  logic        flag_q;
  logic        ovie_q;
  logic        idle_halt_ctrl_q;
  logic        watchdog_q;
  logic [2:0]  tbs_q;
  logic [5:0]  mod_en_q;
  logic [7:0]  rdata_q;
  logic [3:0]  div_cnt_q;
  logic [1:0]  pin_sync_q;
  logic        pin_prev_q;
  logic [1:0]  osc_sync_q;
  logic        osc_prev_q;
  logic [2:0]  osc_div_q;

  logic        tick;
  logic        run;
  logic        rollover;
  logic        wr_mode;
  logic        div12_tick;
  logic        div4_tick;
  logic        pin_fall;
  logic        osc_rise;
  logic        osc_tick;

  assign wr_mode = reg_wr && (reg_addr == `CAT_ADDR_MODE);

  // =====================================================================
  // timebase sources
  // one free divider serves both divided rates; div4 uses its low bits
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 4'h0;
    end else if (div_cnt_q == `CAT_DIV12_COUNT) begin
      div_cnt_q <= 4'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  assign div12_tick = (div_cnt_q == `CAT_DIV12_COUNT);
  assign div4_tick  = (div_cnt_q[1:0] == 2'(`CAT_DIV4_COUNT));

  // pin is asynchronous: two flops before the edge detector
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync_q <= 2'h3;
      pin_prev_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[0], ext_count_input};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  assign pin_fall = pin_prev_q && !pin_sync_q[1];

  // oscillator sampled as a level; each rising edge counted, every eighth one ticks
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_sync_q <= 2'h0;
      osc_prev_q <= 1'b0;
      osc_div_q  <= 3'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[0], ext_osc_clk};
      osc_prev_q <= osc_sync_q[1];
      if (osc_rise) begin
        osc_div_q <= osc_div_q + 3'h1;
      end
    end
  end

  assign osc_rise = osc_sync_q[1] && !osc_prev_q;
  assign osc_tick = osc_rise && (osc_div_q == `CAT_EXT_OSC_DIV);

  always_comb begin
    unique case (cat_pkg::cat_timebase_e'(tbs_q))
      cat_pkg::CAT_TB_DIV12:   tick = div12_tick;
      cat_pkg::CAT_TB_DIV4:    tick = div4_tick;
      cat_pkg::CAT_TB_TMR0:    tick = tmr0_overflow;
      cat_pkg::CAT_TB_EXT_PIN: tick = pin_fall;
      cat_pkg::CAT_TB_SYSCLK:  tick = 1'b1;
      cat_pkg::CAT_TB_EXT_OSC: tick = osc_tick;
      cat_pkg::CAT_TB_RSVD6:   tick = 1'b0;
      cat_pkg::CAT_TB_RSVD7:   tick = 1'b0;
    endcase
  end

  // =====================================================================
  // counter
  // idle gating: halted only when both idle and the halt control are set
  assign run      = !(cpu_idle && idle_halt_ctrl_q);
  assign rollover = run && tick && (count_q == 16'hffff);

  // reads feed nothing here, so counting is unaffected by them
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 16'h0000;
    end else if (run && tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  assign prog_counter_array = count_q;

  // snapshot of the high byte taken on a low-byte read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      snap_high_q <= 8'h00;
    end else if (reg_rd && (reg_addr == `CAT_ADDR_COUNT_LOW)) begin
      snap_high_q <= count_q[15:8];
    end
  end

  // =====================================================================
  // overflow flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else if (rollover) begin
      flag_q <= 1'b1;
    end else if (wr_mode) begin
      flag_q <= reg_wdata[`CAT_MODE_FLAG_BIT];
    end
  end

  assign counter_irq = flag_q && ovie_q;

  // =====================================================================
  // mode register and module enables
  // watchdog set after every reset; while on, selection and idle fields are locked
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_q       <= 1'(`CAT_MODE_RESET >> `CAT_MODE_WDOG_BIT);
      idle_halt_ctrl_q <= 1'b0;
      tbs_q            <= 3'h0;
      ovie_q           <= 1'b0;
    end else if (wr_mode) begin
      watchdog_q <= reg_wdata[`CAT_MODE_WDOG_BIT];
      ovie_q     <= reg_wdata[`CAT_MODE_OVIE_BIT];
      if (!watchdog_q) begin
        idle_halt_ctrl_q <= reg_wdata[`CAT_MODE_IDLE_BIT];
        tbs_q            <= reg_wdata[`CAT_MODE_TBS_HI:`CAT_MODE_TBS_LO];
      end
    end
  end

  assign watchdog_mode = watchdog_q;

  // module 5 enable is forced while the watchdog runs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mod_en_q <= `CAT_MODULE_EN_RESET;
    end else if (reg_wr && (reg_addr == `CAT_ADDR_MODULE_EN) && !watchdog_q) begin
      mod_en_q <= reg_wdata[5:0];
    end
  end

  assign module_enable = {mod_en_q[5] | watchdog_q, mod_en_q[4:0]};

  // =====================================================================
  // read data, valid the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CAT_ADDR_COUNT_LOW:  rdata_q <= count_q[7:0];
        `CAT_ADDR_COUNT_HIGH: rdata_q <= snap_high_q;
        `CAT_ADDR_MODE:       rdata_q <= {idle_halt_ctrl_q, watchdog_q, flag_q, 1'b0, tbs_q, ovie_q};
        `CAT_ADDR_MODULE_EN:  rdata_q <= {2'h0, module_enable};
        default:              rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// [dv/cat_timebase_properties.sv]
// port assertions of the counter array timebase
`timescale 1ns/100ps
module cat_timebase_properties (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [15:0] prog_counter_array,
  input wire logic [5:0]  module_enable,
  input wire logic        watchdog_mode,
  input wire logic        counter_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ====
  // reads
  sequence low_read;
    reg_rd && reg_addr == 8'h00;
  endsequence
  sequence low_then_high;
    low_read ##1 reg_rd && reg_addr == 8'h01;
  endsequence
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  low_byte_a: assert property (low_read |=> reg_rdata == $past(prog_counter_array[7:0]))
    else $error("low byte wrong");
  snap_high_a: assert property (low_then_high |=> reg_rdata == $past(prog_counter_array[15:8], 2))
    else $error("snapshot wrong");
  // ====
  // counting and overflow
  count_step_a:
    assert property (prog_counter_array != $past(prog_counter_array) |-> prog_counter_array == $past(prog_counter_array) + 16'h0001)
    else $error("count jumped");
  irq_cause_a: assert property ($rose(counter_irq) |-> $past(reg_wr) || prog_counter_array <= 16'h0001)
    else $error("irq without cause");
  irq_hold_a: assert property (counter_irq && !reg_wr |=> counter_irq)
    else $error("irq dropped alone");
  // ====
  // watchdog and module enables
  wdog_pin_a: assert property (watchdog_mode |-> module_enable[5])
    else $error("module 5 not enabled");
  wdog_write_a: assert property (watchdog_mode != $past(watchdog_mode) |-> $past(reg_wr) && $past(reg_addr) == 8'h02)
    else $error("watchdog changed alone");
  enable_write_a: assert property (module_enable != $past(module_enable) |-> $past(reg_wr))
    else $error("enables changed alone");
endmodule

bind cat_timebase cat_timebase_properties u_cat_timebase_properties (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .prog_counter_array, .module_enable, .watchdog_mode, .counter_irq);

// [dv/test_counter_array_timebase.sv]
// self-checking bench of the counter array timebase
`timescale 1ns/100ps
module test_counter_array_timebase;
  logic sys_clk, rst_b, reg_wr, reg_rd, cpu_idle, tmr0_overflow, ext_count_input, ext_osc_clk, watchdog_mode, counter_irq;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, lo, hi;
  logic [7:0]  ph = 8'h00;
  logic [15:0] prog_counter_array, c0;
  logic [5:0]  module_enable;
  int          err_total, samples_checked;
  // counts over a 96-cycle window, one per timebase code
  logic [15:0] exp_tab [8] = '{16'h0008, 16'h0018, 16'h000c, 16'h000c, 16'h0060, 16'h0003, 16'h0000, 16'h0000};
  cat_timebase u_cat_timebase (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_idle,
    .tmr0_overflow, .ext_count_input, .ext_osc_clk, .prog_counter_array, .module_enable, .watchdog_mode, .counter_irq);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ====
  // free-running event sources: periods fit the window exactly, so phase never matters
  always @(posedge sys_clk) begin
    ph <= ph + 8'h01;
    tmr0_overflow <= ph[2:0] == 3'h0;
    ext_count_input <= ph[2];
    ext_osc_clk <= ph[1];
  end
  // ====
  // tasks
  task chk(input string n, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(negedge sys_clk);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // low then high with no gap, so the snapshot is read in the very next cycle
  task rd2;
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= 8'h00;
    @(posedge sys_clk);
    reg_addr <= 8'h01;
    @(negedge sys_clk);
    lo = reg_rdata;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    hi = reg_rdata;
  endtask
  task src(input logic [7:0] m, input logic idle, input logic [15:0] e);
    @(posedge sys_clk);
    cpu_idle <= idle;
    wr(8'h02, m);
    repeat (4) @(negedge sys_clk);
    c0 = prog_counter_array;
    repeat (96) @(negedge sys_clk);
    chk("count delta", prog_counter_array - c0, e);
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ====
  // main sequence
  task test_reset_state;
    chk("watchdog", watchdog_mode, 16'h0001);
    wr(8'h03, 8'h3f);
    chk("enables", module_enable, 16'h0020);
    wr(8'h02, 8'h08);
    rd(8'h02, lo);
    chk("mode", lo, 16'h0000);
    wr(8'h03, 8'h3f);
    chk("enables", module_enable, 16'h003f);
  endtask
  task test_sources;
    for (int i = 0; i < 8; i++) src({4'h0, i[2:0], 1'b0}, 1'b0, exp_tab[i]);
    src(8'h08, 1'b1, 16'h0060);
    src(8'h88, 1'b1, 16'h0000);
    src(8'h88, 1'b0, 16'h0060);
  endtask
  // the counter runs every clock here, so the live high byte moves within the 300-cycle wait
  task test_reads;
    wr(8'h02, 8'h08);
    rd2;
    chk("coherent", {hi, lo}, prog_counter_array - 16'h0002);
    rd(8'h00, lo);
    c0 = prog_counter_array - 16'h0001;
    repeat (300) @(negedge sys_clk);
    rd(8'h01, hi);
    chk("snapshot", {hi, lo}, c0);
    rd(8'h10, lo);
    chk("unmapped", lo, 16'h0000);
  endtask
  task test_overflow;
    wr(8'h02, 8'h09);
    for (int n = 0; n < 70000 && counter_irq !== 1'b1; n++) @(negedge sys_clk);
    chk("overflow irq", counter_irq, 16'h0001);
    if (counter_irq !== 1'b1) test_done;
    rd(8'h02, lo);
    chk("flag set", lo, 16'h0029);
    repeat (3) @(negedge sys_clk);
    chk("irq held", counter_irq, 16'h0001);
    wr(8'h02, 8'h09);
    chk("irq cleared", counter_irq, 16'h0000);
    wr(8'h02, 8'h28);
    chk("irq masked", counter_irq, 16'h0000);
    wr(8'h02, 8'h29);
    chk("irq raised", counter_irq, 16'h0001);
  endtask
  task test_rereset;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk("reset again", {module_enable, watchdog_mode, counter_irq}, 16'h0082);
    chk("count reset", prog_counter_array, 16'h0000);
  endtask
  initial begin
    {rst_b, reg_wr, reg_rd, cpu_idle} = '0;
    {reg_addr, reg_wdata} = '0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    test_reset_state;
    test_sources;
    test_reads;
    test_overflow;
    test_rereset;
    test_done;
  end
endmodule
